// ---- verification/aoc_section_counter_asserts.sv ----
// port checks for the section counter
`timescale 1ns/1ps
module aoc_section_counter_asserts
   import aoc_pkg::*;
(
   input wire logic                  core_clk_in,
   input wire logic                  resetn_in,
   input wire logic                  restore_in,
   input wire logic [AOC_POINTS-1:0] point_used_in,
   input wire logic                  clear_contact_out,
   input wire logic [AOC_CNT_W-1:0]  axle_count_out,
   input wire logic                  fail_safe_out,
   input wire logic [AOC_POINTS-1:0] entry_pulse_out,
   input wire logic [AOC_POINTS-1:0] exit_pulse_out
);
   logic restored_ff;

   // contact may only close once a restore was seen since reset
   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) restored_ff <= 1'b0;
      else if (restore_in) restored_ff <= 1'b1;
   end

   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (!resetn_in);

   sequence s_zeroed;
      restore_in ##1 (axle_count_out == 8'h00 && !fail_safe_out);
   endsequence

   a_restore_close: assert property (s_zeroed |-> ##[0:1] clear_contact_out)
      else $error("contact open after restore");
   a_closed_empty: assert property (clear_contact_out |-> axle_count_out == 8'h00)
      else $error("contact closed with axles inside");
   a_count_step: assert property (!$past(restore_in) |-> axle_count_out ==
      8'($past(axle_count_out) + $countones(entry_pulse_out) - $countones(exit_pulse_out)))
      else $error("count step differs from pulses");
   a_unused_quiet: assert property (((entry_pulse_out | exit_pulse_out) & ~point_used_in) == 8'h00)
      else $error("pulse from unused point");
   a_no_early: assert property (clear_contact_out |-> restored_ff)
      else $error("contact closed before restore");
   a_fault_hold: assert property (fail_safe_out && !restore_in |=> fail_safe_out)
      else $error("fail-safe dropped without restore");
   a_fault_open: assert property (fail_safe_out && !restore_in |=> !clear_contact_out)
      else $error("contact closed in fail-safe");
   a_zero_close: assert property ((restored_ff && axle_count_out == 8'h00 && !fail_safe_out)[*2]
      |-> clear_contact_out) else $error("empty section left open");
endmodule : aoc_section_counter_asserts

bind aoc_section_counter aoc_section_counter_asserts aoc_section_counter_asserts_i (
   .core_clk_in(core_clk_in), .resetn_in(resetn_in), .restore_in(restore_in),
   .point_used_in(point_used_in), .clear_contact_out(clear_contact_out),
   .axle_count_out(axle_count_out), .fail_safe_out(fail_safe_out),
   .entry_pulse_out(entry_pulse_out), .exit_pulse_out(exit_pulse_out)
);

// ---- verification/aoc_section_counter_tb.sv ----
// self-checking bench for the section counter
`timescale 1ns/1ps
module aoc_section_counter_tb
   import aoc_pkg::*;
;
   logic                        core_clk_in = 1'b0;
   logic                        resetn_in   = 1'b0;
   logic                        restore_in  = 1'b0;
   logic [15:0]                 cmd         = 16'h0;
   logic [19:0]                 hold        = 20'h0;
   logic [1:0]                  limit       = 2'h2;
   // short filter keeps the run small; steps of 81 cycles outlast it
   localparam int               BENCH_FILT  = 32'h00000040;
   localparam int               RUN_LIMIT   = 32'h000007D0;
   logic [AOC_POINTS-1:0]       busy;
   aoc_loops_t [AOC_POINTS-1:0] loops;
   logic                        clear_c;
   logic [AOC_CNT_W-1:0]        count;
   logic                        fsafe;
   logic [AOC_POINTS-1:0]       ent;
   logic [AOC_POINTS-1:0]       ext;
   logic [AOC_POINTS-1:0]       seen_in     = 8'h00;
   logic [AOC_POINTS-1:0]       seen_out    = 8'h00;
   int                          fails       = 0;
   int                          cmp_count   = 0;

   always #4 core_clk_in = ~core_clk_in;

   for (genvar g = 0; g < AOC_POINTS; g++) begin : gen_pt
      aoc_sensor_model aoc_sensor_model_i (.core_clk_in(core_clk_in), .cmd_in(cmd[2*g +: 2]),
         .hold_in(hold), .loops_out(loops[g]), .busy_out(busy[g]));
   end

   // point 3 is a shared boundary seen inverted, point 7 is not ours
   aoc_section_counter #(.TRANSIENT_CYC(BENCH_FILT)) aoc_section_counter_i (
      .core_clk_in(core_clk_in), .resetn_in(resetn_in),
      .loops_in(loops), .point_used_in(8'h7F), .point_invert_in(8'h08), .fault_limit_in(limit),
      .restore_in(restore_in), .clear_contact_out(clear_c), .axle_count_out(count),
      .fail_safe_out(fsafe), .entry_pulse_out(ent), .exit_pulse_out(ext));

   // pulses last one cycle, so gather them over the whole run
   always @(posedge core_clk_in) begin
      seen_in  <= seen_in | ent;
      seen_out <= seen_out | ext;
   end

   task automatic results();
      if (fails == 0 && cmp_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : results

   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   // start the sensor models given a nonzero cmd at once and wait, bounded, for them to finish
   task automatic run(input logic [15:0] c, input logic [19:0] h);
      int n;
      n = 0;
      hold <= h;
      cmd  <= c;
      @(posedge core_clk_in);
      cmd <= 16'h0;
      do begin
         @(posedge core_clk_in);
         n++;
      end while (|busy && n < RUN_LIMIT);
      if (n >= RUN_LIMIT) begin
         fails++;
         results();
      end
      repeat (4) @(posedge core_clk_in);
   endtask : run

   task automatic t_restore();
      restore_in <= 1'b1;
      @(posedge core_clk_in);
      restore_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      check("count", count, 8'h00);
      check("clear", {7'h0, clear_c}, 8'h01);
      check("failsafe", {7'h0, fsafe}, 8'h00);
   endtask : t_restore

   // a 33-cycle blip is about half the bench filter length
   task automatic t_transient();
      run(16'h0003, 20'h00020);
      check("count", count, 8'h00);
      check("pulses", seen_in | seen_out, 8'h00);
      check("failsafe", {7'h0, fsafe}, 8'h00);
   endtask : t_transient

   task automatic t_entry();
      run(16'h4095, 20'h00050);
      check("count", count, 8'h04);
      check("entries", seen_in, 8'h0F);
      check("exits", seen_out, 8'h00);
      check("clear", {7'h0, clear_c}, 8'h00);
   endtask : t_entry

   task automatic t_exit();
      run(16'h806A, 20'h00050);
      check("count", count, 8'h00);
      check("exits", seen_out, 8'h0F);
      check("clear", {7'h0, clear_c}, 8'h01);
   endtask : t_exit

   // lone loop pulses against limits of two, one and three
   task automatic t_fault();
      run(16'h0300, 20'h00050);
      check("failsafe", {7'h0, fsafe}, 8'h00);
      run(16'h0300, 20'h00050);
      check("failsafe", {7'h0, fsafe}, 8'h01);
      check("clear", {7'h0, clear_c}, 8'h00);
      check("count", count, 8'h00);
      t_restore();
      limit <= 2'h1;
      run(16'h0003, 20'h00050);
      check("failsafe", {7'h0, fsafe}, 8'h01);
      t_restore();
      // two points fail in the same cycle: two of three, then the third
      limit <= 2'h3;
      run(16'h0303, 20'h00050);
      check("failsafe", {7'h0, fsafe}, 8'h00);
      run(16'h0003, 20'h00050);
      check("failsafe", {7'h0, fsafe}, 8'h01);
      t_restore();
   endtask : t_fault

   // mid-run reset must reopen the contact until the next restore
   task automatic t_reset();
      resetn_in <= 1'b0;
      repeat (3) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      check("count", count, 8'h00);
      check("clear", {7'h0, clear_c}, 8'h00);
      t_restore();
   endtask : t_reset

   initial begin
      repeat (20) @(posedge core_clk_in);
      resetn_in <= 1'b1;
      repeat (2) @(posedge core_clk_in);
      check("clear", {7'h0, clear_c}, 8'h00);
      t_restore();
      t_transient();
      t_entry();
      t_exit();
      t_fault();
      t_reset();
      results();
   end
endmodule : aoc_section_counter_tb

// ---- verification/aoc_sensor_model.sv ----
// wheel sensor pair seen through its amplifier
`timescale 1ns/1ps
module aoc_sensor_model
   import aoc_pkg::*;
(
   input  wire logic        core_clk_in,
   input  wire logic [1:0]  cmd_in,
   input  wire logic [19:0] hold_in,
   output aoc_loops_t       loops_out,
   output logic             busy_out
);
   logic [2:0]  step = 3'h0;
   logic [1:0]  mode = 2'h0;
   logic [19:0] cnt  = 20'h0;

   // cmd 1: first loop leads, 2: second leads, 3: lone first loop pulse
   always @(posedge core_clk_in) begin
      if (step == 3'h0) begin
         mode <= cmd_in;
         step <= (cmd_in != 2'h0) ? 3'h1 : 3'h0;
         cnt  <= 20'h0;
      end else if (cnt == hold_in) begin
         step <= (step == 3'h4) ? 3'h0 : step + 3'h1;
         cnt  <= 20'h0;
      end else begin
         cnt <= cnt + 20'h1;
      end
   end

   // released loops drop to the idle low level; step 4 is a settle tail
   always_comb begin
      case (step)
         3'h1: loops_out = (mode == 2'h2) ? 2'h1 : 2'h2;
         3'h2: loops_out = (mode == 2'h3) ? 2'h0 : 2'h3;
         3'h3: loops_out = (mode == 2'h1) ? 2'h1 : ((mode == 2'h2) ? 2'h2 : 2'h0);
         default: loops_out = 2'h0;
      endcase
   end
   assign busy_out = (step != 3'h0);
endmodule : aoc_sensor_model

// ---- verilog/aoc_pkg.sv ----
// shared constants and carrier types for the axle occupancy counter
package aoc_pkg;
   localparam int          AOC_POINTS          = 8;
   localparam int          AOC_CNT_W           = 8;
   localparam int          AOC_CLK_MHZ         = 125;
   localparam int          AOC_TRANSIENT_US    = 4000;
   // transient filter: least time, rounded up to whole cycles
   localparam int          AOC_TRANSIENT_CYC   = (AOC_TRANSIENT_US * AOC_CLK_MHZ);
   localparam int          AOC_FILT_W          = 20;
   localparam logic [AOC_CNT_W-1:0] AOC_CNT_RESET = 8'h00;
   localparam logic [1:0]  AOC_FAULT_RESET     = 2'h0;

   // two raw loop levels of one counting point
   typedef struct packed {
      logic first_loop;
      logic second_sensing_loop;
   } aoc_loops_t;

   // decoder states along an overlapping sequence, gray coded only on the first-loop-leading path
   typedef enum logic [2:0] {
      AOC_IDLE   = 3'b000,
      AOC_A_ONLY = 3'b001,
      AOC_A_BOTH = 3'b011,
      AOC_A_TAIL = 3'b010,
      AOC_B_ONLY = 3'b110,
      AOC_B_BOTH = 3'b111,
      AOC_B_TAIL = 3'b101,
      AOC_BAD    = 3'b100
   } aoc_dir_st_t;

   // one-cycle events from one counting point
   typedef struct packed {
      logic entry;
      logic exit_ev;
      logic bad;
   } aoc_event_t;
endpackage : aoc_pkg

// ---- verilog/aoc_point_decoder.sv ----
// one counting point: transient filters and direction decoder
`timescale 1ns/1ps
module aoc_point_decoder
   import aoc_pkg::*;
#(
   // least steady run of a loop level, in cycles
   parameter int TRANSIENT_CYC = AOC_TRANSIENT_CYC
)
(
   input  wire logic       core_clk_in,
   input  wire logic       resetn_in,
   input  wire aoc_loops_t loops_in,
   output aoc_event_t      event_out
);
   typedef struct packed {
      logic [AOC_FILT_W-1:0] cnt_a;
      logic [AOC_FILT_W-1:0] cnt_b;
      logic                  la;
      logic                  lb;
      aoc_dir_st_t           st;
      aoc_event_t            ev;
   } aoc_pd_state_t;

   aoc_pd_state_t st_ff;
   aoc_pd_state_t nxt_st;

   // filtered level follows raw only after a steady run
   function automatic logic [AOC_FILT_W-1:0] filt_cnt(input logic raw, input logic lvl,
                                                     input logic [AOC_FILT_W-1:0] c);
      if (raw == lvl) begin
         filt_cnt = '0;
      end else begin
         filt_cnt = c + 20'h00001;
      end
   endfunction : filt_cnt

   always_comb begin
      logic a;
      logic b;
      a = 1'b0;
      b = 1'b0;
      nxt_st = st_ff;
      nxt_st.ev = '0;
      // short pulses never reach the decoder
      nxt_st.cnt_a = filt_cnt(loops_in.first_loop, st_ff.la, st_ff.cnt_a);          // RULE_09
      nxt_st.cnt_b = filt_cnt(loops_in.second_sensing_loop, st_ff.lb, st_ff.cnt_b); // RULE_09
      if (nxt_st.cnt_a == AOC_FILT_W'(TRANSIENT_CYC)) begin
         nxt_st.la    = ~st_ff.la;
         nxt_st.cnt_a = '0;
      end
      if (nxt_st.cnt_b == AOC_FILT_W'(TRANSIENT_CYC)) begin
         nxt_st.lb    = ~st_ff.lb;
         nxt_st.cnt_b = '0;
      end
      a = nxt_st.la;
      b = nxt_st.lb;
      // order of loops gives direction; full overlap required
      case (st_ff.st)
         AOC_IDLE: begin
            if (a && b) nxt_st.st = AOC_BAD;
            else if (a) nxt_st.st = AOC_A_ONLY;                          // RULE_07
            else if (b) nxt_st.st = AOC_B_ONLY;                          // RULE_07
         end
         AOC_A_ONLY: begin
            if (a && b) nxt_st.st = AOC_A_BOTH;                          // RULE_08
            else if (!a) nxt_st.st = AOC_BAD;
         end
         AOC_A_BOTH: begin
            if (!a && b) nxt_st.st = AOC_A_TAIL;                         // RULE_08
            else if (!(a && b)) nxt_st.st = AOC_BAD;
         end
         AOC_A_TAIL: begin
            if (!b && !a) begin
               nxt_st.st       = AOC_IDLE;
               nxt_st.ev.entry = 1'b1;                                   // RULE_07
            end else if (a) nxt_st.st = AOC_BAD;
         end
         AOC_B_ONLY: begin
            if (a && b) nxt_st.st = AOC_B_BOTH;                          // RULE_08
            else if (!b) nxt_st.st = AOC_BAD;
         end
         AOC_B_BOTH: begin
            if (a && !b) nxt_st.st = AOC_B_TAIL;                         // RULE_08
            else if (!(a && b)) nxt_st.st = AOC_BAD;
         end
         AOC_B_TAIL: begin
            if (!a && !b) begin
               nxt_st.st         = AOC_IDLE;
               nxt_st.ev.exit_ev = 1'b1;                                 // RULE_07
            end else if (b) nxt_st.st = AOC_BAD;
         end
         default: begin
            // a disassociated pulse is reported once both loops are free
            if (!a && !b) begin
               nxt_st.st     = AOC_IDLE;
               nxt_st.ev.bad = 1'b1;                                     // RULE_10
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_ff <= '{cnt_a: '0, cnt_b: '0, la: 1'b0, lb: 1'b0, st: AOC_IDLE, ev: '0};
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign event_out = st_ff.ev;
endmodule : aoc_point_decoder

// ---- verilog/aoc_section_counter.sv ----
// section occupancy: eight counting points feed one axle count
`timescale 1ns/1ps
// Contract
// (RULE_01) entry across a boundary adds one
// (RULE_02) exit across a boundary subtracts one
// (RULE_03) nonzero count holds clear contact open
// (RULE_04) zero count closes clear contact
// (RULE_05) one sensor may serve two sections
// (RULE_06) up to eight points summed into count
// (RULE_07) loop order gives entry or exit
// (RULE_08) count only after full overlap sequence
// (RULE_09) pulses under four milliseconds are suppressed
// (RULE_10) one to three bad pulses force fail-safe
// (RULE_11) occupied after reset until restored to zero
module aoc_section_counter
   import aoc_pkg::*;
#(
   // filter length; hardware keeps the 4 ms default, a bench may shorten it
   parameter int TRANSIENT_CYC = AOC_TRANSIENT_CYC
)
(
   input  wire logic                 core_clk_in,
   input  wire logic                 resetn_in,
   input  wire aoc_loops_t [AOC_POINTS-1:0] loops_in,
   input  wire logic [AOC_POINTS-1:0] point_used_in,
   input  wire logic [AOC_POINTS-1:0] point_invert_in,
   input  wire logic [1:0]           fault_limit_in,
   input  wire logic                 restore_in,
   output logic                      clear_contact_out,
   output logic [AOC_CNT_W-1:0]      axle_count_out,
   output logic                      fail_safe_out,
   output logic [AOC_POINTS-1:0]     entry_pulse_out,
   output logic [AOC_POINTS-1:0]     exit_pulse_out
);
   typedef struct packed {
      logic [AOC_CNT_W-1:0]  count;
      logic [1:0]            faults;
      logic                  fail_safe;
      logic                  restored;
      logic                  clear;
      logic [AOC_POINTS-1:0] ent;
      logic [AOC_POINTS-1:0] ext;
   } aoc_sc_state_t;

   aoc_sc_state_t st_ff;
   aoc_sc_state_t nxt_st;
   aoc_event_t [AOC_POINTS-1:0] pev;

   // one decoder per counting point; the same events may also feed a neighbour
   for (genvar g = 0; g < AOC_POINTS; g++) begin : g_pt
      aoc_point_decoder #(
         .TRANSIENT_CYC (TRANSIENT_CYC)
      ) u_dec (
         .core_clk_in (core_clk_in),
         .resetn_in   (resetn_in),
         .loops_in    (loops_in[g]),
         .event_out   (pev[g])
      );
   end

   // population count of an event vector
   function automatic logic [3:0] pop8(input logic [AOC_POINTS-1:0] v);
      pop8 = 4'h0;
      for (int i = 0; i < AOC_POINTS; i++) begin
         pop8 = pop8 + {3'h0, v[i]};
      end
   endfunction : pop8

   always_comb begin
      logic [AOC_POINTS-1:0] inc;
      logic [AOC_POINTS-1:0] dec;
      logic [AOC_POINTS-1:0] bad;
      logic [3:0]            n_bad;
      logic [2:0]            lim;
      inc    = '0;
      dec    = '0;
      bad    = '0;
      n_bad  = 4'h0;
      lim    = 3'h0;
      nxt_st = st_ff;
      // inverted point counts the sensor's exit as this section's entry
      for (int i = 0; i < AOC_POINTS; i++) begin
         inc[i] = point_used_in[i] &
                  (point_invert_in[i] ? pev[i].exit_ev : pev[i].entry);   // RULE_05
         dec[i] = point_used_in[i] &
                  (point_invert_in[i] ? pev[i].entry : pev[i].exit_ev);   // RULE_05
         bad[i] = point_used_in[i] & pev[i].bad;
      end
      nxt_st.ent = inc;
      nxt_st.ext = dec;
      // simultaneous events from all used points combine in one step
      nxt_st.count = st_ff.count + AOC_CNT_W'(pop8(inc))                 // RULE_01 RULE_06
                                 - AOC_CNT_W'(pop8(dec));                // RULE_02 RULE_06
      // limit of zero is taken as one: never weaker than the strictest
      lim   = (fault_limit_in == 2'h0) ? 3'h1 : {1'b0, fault_limit_in};
      n_bad = pop8(bad);
      // five bits wide so eight bad points at once cannot wrap past the limit
      if ({3'h0, st_ff.faults} + {1'b0, n_bad} >= {2'h0, lim}) begin
         nxt_st.fail_safe = 1'b1;                                        // RULE_10
         nxt_st.faults    = fault_limit_in;
      end else begin
         nxt_st.faults = st_ff.faults + n_bad[1:0];
      end
      // restore sets a known zero and lifts fail-safe; a fault in the same cycle wins
      if (restore_in) begin
         nxt_st.count    = AOC_CNT_RESET;                                // RULE_11
         nxt_st.restored = 1'b1;
         if (n_bad == 4'h0) begin
            nxt_st.fail_safe = 1'b0;
            nxt_st.faults    = AOC_FAULT_RESET;
         end
      end
      // contact closed only on zero count, restored, and no fail-safe
      nxt_st.clear = (nxt_st.count == AOC_CNT_RESET) &                   // RULE_03 RULE_04
                     nxt_st.restored & ~nxt_st.fail_safe;                // RULE_10 RULE_11
   end

   always_ff @(posedge core_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_ff <= '{count: AOC_CNT_RESET, faults: AOC_FAULT_RESET, fail_safe: 1'b0,
                    restored: 1'b0, clear: 1'b0, ent: '0, ext: '0};     // RULE_11
      end else begin
         st_ff <= nxt_st;
      end
   end

   assign clear_contact_out = st_ff.clear;
   assign axle_count_out    = st_ff.count;
   assign fail_safe_out     = st_ff.fail_safe;
   assign entry_pulse_out   = st_ff.ent;
   assign exit_pulse_out    = st_ff.ext;
endmodule : aoc_section_counter
